// ---- rtl/cgi_config_port.sv ----
// Two-wire target configuration port with staged writes, general control,
// variant code, output divider decoding, spread offset, suspend and VCO ramp.
// Assumes SCL and SDA arrive asynchronously and SDA is an open-drain wire.
//
// Function
// - Act only as a bus target at 0xD0, 0xD2, 0xD4 or 0xD6.
// - Address select field 00/01/10/11 picks D0/D2/D4/D6, resets to 00.
// - Support byte-oriented block write and block read only.
// - Successive bytes go to ascending positions, most significant bit first.
// - Transfers may end after any complete byte without error.
// - Written bytes are staged and all committed together at STOP.
// - Divider one decodes code by row bits 1:0 and column bits 3:2.
// - Dividers two, four and five decode with their own table.
// - Divider three decodes with its own table.
// - Bit 7 shows nonvolatile programmed, bit 0 locks nonvolatile writes.
// - Bit 4 enables first PLL spread, reset disabled.
// - Bits 3, 2, 1 select divider source, third PLL reference, clock input.
// - Readable writable variant byte at position one, resets to zero.
// - Spread is down only, amount between -0.5% and -2%; the code also offers center spread on i_center_spread.
// - Center spread adds half the spread fraction times ratio as offset.
// - On battery only, give 32kHz outputs; resume automatically on power.
// - Frequency changes steer the VCO gradually toward the new target.
`default_nettype none
module cgi_config_port #(
  parameter int STEP_CYCLES = cgi_pkg::RAMP_STEP_CYCLES
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output var  logic        o_sda,
  output var  logic        o_sda_oe_n,
  output var  logic        o_nvm_programmed,
  output var  logic [1:0]  o_addr_select,
  output var  logic        o_first_pll_spread_enable,
  output var  logic        o_first_divider_source_select,
  output var  logic        o_third_pll_reference_select,
  output var  logic        o_external_clock_input_enable,
  output var  logic        o_nvm_write_lock,
  output var  logic [7:0]  o_variant_code,
  input  wire logic [3:0]  i_div1_code,
  input  wire logic [3:0]  i_div2_code,
  input  wire logic [3:0]  i_div3_code,
  input  wire logic [3:0]  i_div4_code,
  input  wire logic [3:0]  i_div5_code,
  output var  logic [6:0]  o_div1_ratio,
  output var  logic [6:0]  o_div2_ratio,
  output var  logic [6:0]  o_div3_ratio,
  output var  logic [6:0]  o_div4_ratio,
  output var  logic [6:0]  o_div5_ratio,
  input  wire logic [15:0] i_pll2_ratio,
  input  wire logic        i_center_spread,
  input  wire logic [7:0]  i_spread_fraction,
  output var  logic [15:0] o_pll2_divide_ratio,
  input  wire logic        i_core_power,
  output var  logic        o_suspend_32k,
  input  wire logic [11:0] i_vco_target,
  output var  logic [11:0] o_vco_setting
);
  import cgi_pkg::*;

  logic [1:0]  rst_sync;
  logic        rst_n;
  logic [2:0]  scl_sync;
  logic [2:0]  sda_sync;
  logic [2:0]  pwr_sync;
  logic        scl_f;
  logic        sda_f;
  logic        scl_prev;
  logic        sda_prev;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_seen;
  logic        stop_seen;
  cgi_state_t  state;
  logic [3:0]  bit_cnt;
  logic [7:0]  shift;
  logic        is_read;
  logic [1:0]  rx_idx;
  logic [15:0] reg_ptr;
  logic [7:0]  tx_byte;
  logic        master_ack;
  logic [7:0]  regs   [NUM_REGS];
  logic [7:0]  stage  [NUM_REGS];
  logic        staged [NUM_REGS];
  logic [7:0]  rd_data;
  logic [3:0]  div_code [5];
  logic [6:0]  div_ratio [5];
  logic [7:0]  frac_lim;
  logic [23:0] spread_prod;
  logic [31:0] step_cnt;

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // A level change counts only once the second and third stages agree.
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
      // Power counts as present at reset, so no false suspend pulse follows it.
      pwr_sync <= 3'h7;
      scl_f    <= 1'b1;
      sda_f    <= 1'b1;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[1:0], i_scl};
      sda_sync <= {sda_sync[1:0], i_sda};
      pwr_sync <= {pwr_sync[1:0], i_core_power};
      if (scl_sync[1] == scl_sync[2]) begin
        scl_f <= scl_sync[2];
      end
      if (sda_sync[1] == sda_sync[2]) begin
        sda_f <= sda_sync[2];
      end
      scl_prev <= scl_f;
      sda_prev <= sda_f;
    end
  end

  assign scl_rise   = scl_f && !scl_prev;
  assign scl_fall   = !scl_f && scl_prev;
  assign start_seen = scl_f && scl_prev && sda_prev && !sda_f;
  assign stop_seen  = scl_f && scl_prev && !sda_prev && sda_f;

  // Unmapped positions read as zero.
  assign rd_data = (reg_ptr < 16'(NUM_REGS)) ? regs[reg_ptr[0]] : 8'h00;

  // Protocol engine; SDA only changes while SCL is low.
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state      <= ST_IDLE;
      bit_cnt    <= 4'h0;
      shift      <= 8'h00;
      is_read    <= 1'b0;
      rx_idx     <= 2'h0;
      reg_ptr    <= 16'h0000;
      tx_byte    <= 8'h00;
      master_ack <= 1'b0;
      o_sda_oe_n <= 1'b1;
      o_sda      <= 1'b0;
    end else if (start_seen) begin
      state      <= ST_ADDR;
      bit_cnt    <= 4'h0;
      rx_idx     <= 2'h0;
      o_sda_oe_n <= 1'b1;
    end else if (stop_seen) begin
      state      <= ST_IDLE;
      o_sda_oe_n <= 1'b1;
    end else if (scl_rise) begin
      unique case (state)
        ST_ADDR, ST_RX: begin
          shift   <= {shift[6:0], sda_f};
          bit_cnt <= bit_cnt + 4'h1;
        end
        ST_TX: begin
          bit_cnt <= bit_cnt + 4'h1;
        end
        ST_TX_ACK: begin
          master_ack <= !sda_f;
        end
        ST_IDLE, ST_ADDR_ACK, ST_RX_ACK: begin
        end
      endcase
    end else if (scl_fall) begin
      unique case (state)
        ST_ADDR: begin
          if (bit_cnt == 4'h8) begin
            // Match against the committed select field only.
            if (shift[7:1] == TARGET_BASE + {5'h00, regs[0][BIT_ADDR_SEL_HI:BIT_ADDR_SEL_LO]}) begin
              state      <= ST_ADDR_ACK;
              is_read    <= shift[0];
              o_sda_oe_n <= 1'b0;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          bit_cnt <= 4'h0;
          if (is_read) begin
            state      <= ST_TX;
            tx_byte    <= rd_data;
            o_sda_oe_n <= rd_data[7];
            reg_ptr    <= reg_ptr + 16'h0001;
          end else begin
            state      <= ST_RX;
            o_sda_oe_n <= 1'b1;
          end
        end
        ST_RX: begin
          if (bit_cnt == 4'h8) begin
            state      <= ST_RX_ACK;
            o_sda_oe_n <= 1'b0;
            if (rx_idx == 2'h0) begin
              reg_ptr[15:8] <= shift;
              rx_idx        <= 2'h1;
            end else if (rx_idx == 2'h1) begin
              reg_ptr[7:0] <= shift;
              rx_idx       <= 2'h2;
            end else begin
              reg_ptr <= reg_ptr + 16'h0001;
            end
          end
        end
        ST_RX_ACK: begin
          state      <= ST_RX;
          bit_cnt    <= 4'h0;
          o_sda_oe_n <= 1'b1;
        end
        ST_TX: begin
          if (bit_cnt == 4'h8) begin
            state      <= ST_TX_ACK;
            o_sda_oe_n <= 1'b1;
          end else begin
            o_sda_oe_n <= tx_byte[3'(4'h7 - bit_cnt)];
          end
        end
        ST_TX_ACK: begin
          bit_cnt <= 4'h0;
          if (master_ack) begin
            state      <= ST_TX;
            tx_byte    <= rd_data;
            o_sda_oe_n <= rd_data[7];
            reg_ptr    <= reg_ptr + 16'h0001;
          end else begin
            state <= ST_IDLE;
          end
        end
        ST_IDLE: begin
        end
      endcase
    end
  end

  // Staging and commit; readers never see staged bytes before the stop.
  generate
    for (genvar r = 0; r < NUM_REGS; r++) begin : g_reg
      localparam logic [7:0] RST = (r == 0) ? GENERAL_CONTROL_RESET : VARIANT_CODE_RESET;
      always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
          regs[r]   <= RST;
          stage[r]  <= 8'h00;
          staged[r] <= 1'b0;
        end else if (stop_seen) begin
          if (staged[r]) begin
            regs[r] <= stage[r];
          end
          staged[r] <= 1'b0;
        end else if (scl_fall && state == ST_RX && bit_cnt == 4'h8 && rx_idx == 2'h2
                     && reg_ptr == 16'(r)) begin
          stage[r]  <= shift;
          staged[r] <= 1'b1;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_nvm_programmed              <= 1'b0;
      o_addr_select                 <= 2'h0;
      o_first_pll_spread_enable     <= 1'b0;
      o_first_divider_source_select <= 1'b0;
      o_third_pll_reference_select  <= 1'b0;
      o_external_clock_input_enable <= 1'b0;
      o_nvm_write_lock              <= 1'b0;
      o_variant_code                <= VARIANT_CODE_RESET;
    end else begin
      o_nvm_programmed              <= regs[0][BIT_NVM_PROGRAMMED];
      o_addr_select                 <= regs[0][BIT_ADDR_SEL_HI:BIT_ADDR_SEL_LO];
      o_first_pll_spread_enable     <= regs[0][BIT_SPREAD_EN];
      o_first_divider_source_select <= regs[0][BIT_DIV1_SRC];
      o_third_pll_reference_select  <= regs[0][BIT_PLL3_REF];
      o_external_clock_input_enable <= regs[0][BIT_CLKIN_EN];
      o_nvm_write_lock              <= regs[0][BIT_NVM_LOCK];
      o_variant_code                <= regs[1];
    end
  end

  assign div_code[0] = i_div1_code;
  assign div_code[1] = i_div2_code;
  assign div_code[2] = i_div3_code;
  assign div_code[3] = i_div4_code;
  assign div_code[4] = i_div5_code;

  generate
    for (genvar d = 0; d < 5; d++) begin : g_div
      always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
          div_ratio[d] <= 7'h01;
        end else if (d == 0) begin
          div_ratio[d] <= DIV1_TABLE[{div_code[d][1:0], div_code[d][3:2]}];
        end else if (d == 2) begin
          div_ratio[d] <= DIV3_TABLE[{div_code[d][1:0], div_code[d][3:2]}];
        end else begin
          div_ratio[d] <= DIV245_TABLE[{div_code[d][1:0], div_code[d][3:2]}];
        end
      end
    end
  endgenerate

  assign o_div1_ratio = div_ratio[0];
  assign o_div2_ratio = div_ratio[1];
  assign o_div3_ratio = div_ratio[2];
  assign o_div4_ratio = div_ratio[3];
  assign o_div5_ratio = div_ratio[4];

  // Out-of-range amounts are clamped rather than rejected.
  assign frac_lim = (i_spread_fraction < SPREAD_MIN_CODE) ? SPREAD_MIN_CODE :
                    (i_spread_fraction > SPREAD_MAX_CODE) ? SPREAD_MAX_CODE :
                    i_spread_fraction;
  assign spread_prod = i_pll2_ratio * {8'h00, frac_lim};

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_pll2_divide_ratio <= 16'h0000;
    end else if (i_center_spread) begin
      o_pll2_divide_ratio <= i_pll2_ratio + 16'(spread_prod >> SPREAD_HALF_SHIFT);
    end else begin
      o_pll2_divide_ratio <= i_pll2_ratio;
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_suspend_32k <= 1'b0;
    end else if (pwr_sync[1] == pwr_sync[2]) begin
      o_suspend_32k <= !pwr_sync[2];
    end
  end

  // One step per period keeps the output free of frequency spikes.
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      step_cnt      <= 32'h00000000;
      o_vco_setting <= 12'h000;
    end else if (step_cnt >= 32'(STEP_CYCLES - 1)) begin
      step_cnt <= 32'h00000000;
      if (o_vco_setting < i_vco_target) begin
        o_vco_setting <= o_vco_setting + 12'h001;
      end else if (o_vco_setting > i_vco_target) begin
        o_vco_setting <= o_vco_setting - 12'h001;
      end
    end else begin
      step_cnt <= step_cnt + 32'h00000001;
    end
  end
endmodule : cgi_config_port
`default_nettype wire

// ---- rtl/cgi_pkg.sv ----
// Constants for the clock generator configuration port.
// Assumes a single 100 MHz core clock; all offsets are byte positions.
`default_nettype none
package cgi_pkg;
  localparam int CLK_PERIOD_NS = 10;
  // Bus address base 0xD0 in 7-bit form; the select field adds 0..3.
  localparam logic [6:0] TARGET_BASE = 7'h68;
  localparam int NUM_REGS = 2;
  localparam logic [15:0] OFS_GENERAL_CONTROL = 16'h0000;
  localparam logic [15:0] OFS_VARIANT_CODE = 16'h0001;
  localparam logic [7:0] GENERAL_CONTROL_RESET = 8'h00;
  localparam logic [7:0] VARIANT_CODE_RESET = 8'h00;
  localparam int BIT_NVM_PROGRAMMED = 7;
  localparam int BIT_ADDR_SEL_HI = 6;
  localparam int BIT_ADDR_SEL_LO = 5;
  localparam int BIT_SPREAD_EN = 4;
  localparam int BIT_DIV1_SRC = 3;
  localparam int BIT_PLL3_REF = 2;
  localparam int BIT_CLKIN_EN = 1;
  localparam int BIT_NVM_LOCK = 0;
  // Spread fraction in units of 1/4096 of the divide ratio: -0.5% to -2%.
  localparam logic [7:0] SPREAD_MIN_CODE = 8'h15;
  localparam logic [7:0] SPREAD_MAX_CODE = 8'h51;
  localparam int SPREAD_HALF_SHIFT = 13;
  // Ramp limiter step period.
  localparam int RAMP_STEP_NS = 1000;
  localparam int RAMP_STEP_CYCLES = (RAMP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Divider tables indexed by {code[1:0], code[3:2]}.
  localparam logic [6:0] DIV1_TABLE [16] = '{
    7'h01, 7'h02, 7'h04, 7'h08, 7'h04, 7'h08, 7'h10, 7'h20,
    7'h05, 7'h0A, 7'h14, 7'h28, 7'h06, 7'h0C, 7'h18, 7'h30};
  localparam logic [6:0] DIV245_TABLE [16] = '{
    7'h01, 7'h02, 7'h04, 7'h05, 7'h03, 7'h06, 7'h0C, 7'h0F,
    7'h05, 7'h0A, 7'h14, 7'h19, 7'h0A, 7'h14, 7'h28, 7'h32};
  localparam logic [6:0] DIV3_TABLE [16] = '{
    7'h01, 7'h02, 7'h04, 7'h08, 7'h03, 7'h06, 7'h0C, 7'h18,
    7'h05, 7'h0A, 7'h14, 7'h28, 7'h0A, 7'h14, 7'h28, 7'h50};
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK
  } cgi_state_t;
endpackage : cgi_pkg
`default_nettype wire

// ---- verif/cgi_config_port_props.sv ----
// Checker for the configuration port, bound to its top module.
// Assumes one core clock and the active-low reset seen at the pins.
`default_nettype none
module cgi_config_port_props #(
  parameter int STEP_CYCLES = 2
) (
  input wire logic        i_core_clk,
  input wire logic        i_rstn,
  input wire logic        i_scl,
  input wire logic        i_sda,
  input wire logic        o_sda,
  input wire logic        o_sda_oe_n,
  input wire logic [7:0]  o_variant_code,
  input wire logic [3:0]  i_div1_code,
  input wire logic [3:0]  i_div2_code,
  input wire logic [3:0]  i_div3_code,
  input wire logic [6:0]  o_div1_ratio,
  input wire logic [6:0]  o_div2_ratio,
  input wire logic [6:0]  o_div3_ratio,
  input wire logic        i_core_power,
  input wire logic        o_suspend_32k,
  input wire logic [11:0] i_vco_target,
  input wire logic [11:0] o_vco_setting
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STEP_WIN = STEP_CYCLES + 3;
  logic [1:0] run;
  logic [3:0] since_stop;
  // The internal reset copy lags the pin, so relations wait a few cycles.
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) run <= 2'h0;
    else if (run != 2'h3) run <= run + 2'h1;
  end
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) since_stop <= 4'hF;
    else if (i_scl && $rose(i_sda)) since_stop <= 4'h0;
    else if (since_stop != 4'hF) since_stop <= since_stop + 4'h1;
  end
  function automatic logic [6:0] ratio(input int kind, input logic [3:0] c);
    int b;
    b = (kind == 1) ? ((c[1:0] == 2'h0) ? 1 : c[1:0] + 3) :
                      ((c[1:0] == 2'h3) ? 10 : 2 * c[1:0] + 1);
    if (kind == 2 && c[3:2] == 2'h3) return 7'(b * 5);
    return 7'(b << c[3:2]);
  endfunction : ratio
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  property p_sda_low; o_sda == 1'b0; endproperty
  a_sda_low: assert property (p_sda_low) else $error("data out not low");
  property p_div1; run == 2'h3 |=> o_div1_ratio == ratio(1, $past(i_div1_code)); endproperty
  a_div1: assert property (p_div1) else $error("divider one ratio");
  property p_div2; run == 2'h3 |=> o_div2_ratio == ratio(2, $past(i_div2_code)); endproperty
  a_div2: assert property (p_div2) else $error("divider two ratio");
  property p_div3; run == 2'h3 |=> o_div3_ratio == ratio(3, $past(i_div3_code)); endproperty
  a_div3: assert property (p_div3) else $error("divider three ratio");
  property p_suspend;
    (run == 2'h3 && $stable(i_core_power)) [*8] |-> o_suspend_32k == !i_core_power;
  endproperty
  a_suspend: assert property (p_suspend) else $error("suspend flag");
  property p_vco_step;
    run == 2'h3 && o_vco_setting != $past(o_vco_setting) |->
      o_vco_setting == $past(o_vco_setting) + 12'h1 ||
      o_vco_setting == $past(o_vco_setting) - 12'h1;
  endproperty
  a_vco_step: assert property (p_vco_step) else $error("vco jumped");
  property p_vco_move;
    run == 2'h3 && o_vco_setting != i_vco_target && $stable(i_vco_target) |->
      ##[1:STEP_WIN] ($changed(o_vco_setting) || $changed(i_vco_target));
  endproperty
  a_vco_move: assert property (p_vco_move) else $error("vco stalled");
  property p_stop_release; i_scl && $rose(i_sda) |-> ##[1:8] o_sda_oe_n; endproperty
  a_stop_release: assert property (p_stop_release) else $error("held after stop");
  property p_drive_low_scl; $fell(o_sda_oe_n) |-> !i_scl; endproperty
  a_drive_low_scl: assert property (p_drive_low_scl) else $error("clock high at drive");
  property p_commit; run == 2'h3 && $changed(o_variant_code) |-> since_stop <= 4'hA; endproperty
  a_commit: assert property (p_commit) else $error("update without stop");
  c_commit: cover property ($changed(o_variant_code));
  c_stop: cover property (i_scl && $rose(i_sda));
  c_suspend: cover property ($rose(o_suspend_32k));
endmodule : cgi_config_port_props
`default_nettype wire

// ---- verif/cgi_config_port_tb.sv ----
// Self-checking bench for the configuration port.
// Assumes the controller model cgi_i2c_ctrl and the checker cgi_config_port_props.
`default_nettype none
module cgi_config_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_core_clk, i_rstn, i_center_spread, i_core_power, ctl_sda;
  wire logic i_scl, i_sda;
  logic [3:0] i_div1_code, i_div2_code, i_div3_code, i_div4_code, i_div5_code, cd;
  logic [15:0] i_pll2_ratio, o_pll2_divide_ratio, q;
  logic [7:0] i_spread_fraction, o_variant_code, cur, nxt;
  logic [11:0] i_vco_target, o_vco_setting;
  logic o_sda, o_sda_oe_n, o_nvm_programmed, o_first_pll_spread_enable, o_suspend_32k;
  logic o_first_divider_source_select, o_third_pll_reference_select;
  logic o_external_clock_input_enable, o_nvm_write_lock, ok;
  logic [1:0] o_addr_select, sel;
  logic [6:0] o_div1_ratio, o_div2_ratio, o_div3_ratio, o_div4_ratio, o_div5_ratio;
  int num_errors = 0, checked = 0, cyc = 0;
  // Divider ratios {one, two/four/five, three} in row-major order.
  logic [23:0] rows [16] = '{24'h010101, 24'h020202, 24'h040404, 24'h080508,
    24'h040303, 24'h080606, 24'h100C0C, 24'h200F18, 24'h050505, 24'h0A0A0A,
    24'h141414, 24'h281928, 24'h060A0A, 24'h0C1414, 24'h182828, 24'h303250};
  // Open-drain wire: low while either party pulls.
  assign i_sda = ctl_sda & o_sda_oe_n;
  cgi_config_port #(.STEP_CYCLES(2)) cgi_config_port_i (.*);
  cgi_i2c_ctrl cgi_i2c_ctrl_i (.i_core_clk, .i_sda, .o_scl(i_scl), .o_sda(ctl_sda));
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  task automatic report_and_stop();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic [7:0] a, input logic [15:0] p, input int n,
                      input logic [15:0] d, input logic stp, output logic ak);
    logic k;
    cgi_i2c_ctrl_i.start();
    cgi_i2c_ctrl_i.wbyte(a, ak);
    if (ak) begin
      cgi_i2c_ctrl_i.wbyte(p[15:8], k);
      cgi_i2c_ctrl_i.wbyte(p[7:0], k);
      for (int i = 0; i < n; i++) begin
        cgi_i2c_ctrl_i.wbyte(d[15-8*i -: 8], k);
        chk(k, 1'b1);
      end
    end
    if (stp) cgi_i2c_ctrl_i.stop();
  endtask : xfer
  task automatic rd(input logic [7:0] a, input logic [15:0] p, input int n, output logic [15:0] r);
    logic k;
    logic [7:0] b;
    xfer(a, p, 0, 16'h0000, 1'b0, k);
    cgi_i2c_ctrl_i.start();
    cgi_i2c_ctrl_i.wbyte(a | 8'h01, k);
    r = 16'h0000;
    for (int i = 0; i < n; i++) begin
      cgi_i2c_ctrl_i.rbyte(i == n - 1, b);
      r = {r[7:0], b};
    end
    cgi_i2c_ctrl_i.stop();
  endtask : rd
  task automatic pll(input logic [7:0] f, input logic c, input logic [15:0] e);
    i_pll2_ratio <= 16'h1000;
    i_spread_fraction <= f;
    i_center_spread <= c;
    repeat (3) @(posedge i_core_clk);
    chk(o_pll2_divide_ratio, e);
  endtask : pll
  initial begin
    {i_rstn, i_center_spread, i_pll2_ratio, i_spread_fraction, i_vco_target} = '0;
    {i_div1_code, i_div2_code, i_div3_code, i_div4_code, i_div5_code} = '0;
    i_core_power = 1'b1;
    repeat (12) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    repeat (4) @(posedge i_core_clk);
    chk(o_suspend_32k, 1'b0);
    repeat (4) @(posedge i_core_clk);
    chk({o_sda_oe_n, o_vco_setting, o_variant_code}, 21'h100000);
    chk({o_nvm_programmed, o_addr_select, o_first_pll_spread_enable,
         o_first_divider_source_select, o_third_pll_reference_select,
         o_external_clock_input_enable, o_nvm_write_lock}, 8'h00);
    rd(8'hD0, 16'h0000, 2, q);
    chk(q, 16'h0000);
    for (int i = 0; i < 16; i++) begin
      cd = {i[1:0], i[3:2]};
      {i_div1_code, i_div2_code, i_div3_code, i_div4_code, i_div5_code} <= {5{cd}};
      repeat (2) @(posedge i_core_clk);
      chk({1'b0, o_div1_ratio, 1'b0, o_div2_ratio, 1'b0, o_div3_ratio}, rows[i]);
      chk({1'b0, o_div4_ratio, 1'b0, o_div5_ratio}, {2{rows[i][15:8]}});
    end
    pll(8'h20, 1'b1, 16'h1010);
    pll(8'h20, 1'b0, 16'h1000);
    pll(8'h05, 1'b1, 16'h100A);
    pll(8'hFF, 1'b1, 16'h1028);
    xfer(8'hD0, 16'h0000, 2, 16'h9FA5, 1'b0, ok);
    repeat (20) @(posedge i_core_clk);
    chk({o_nvm_programmed, o_variant_code}, 9'h000);
    cgi_i2c_ctrl_i.stop();
    repeat (10) @(posedge i_core_clk);
    chk({o_nvm_programmed, o_addr_select, o_first_pll_spread_enable,
         o_first_divider_source_select, o_third_pll_reference_select,
         o_external_clock_input_enable, o_nvm_write_lock}, 8'h9F);
    chk(o_variant_code, 8'hA5);
    rd(8'hD0, 16'h0000, 2, q);
    chk(q, 16'h9FA5);
    xfer(8'hD0, 16'h0002, 1, 16'h7700, 1'b1, ok);
    xfer(8'hD0, 16'h0001, 1, 16'h3300, 1'b0, ok);
    rd(8'hD0, 16'h0001, 2, q);
    chk(q, 16'hA500);
    repeat (10) @(posedge i_core_clk);
    chk(o_variant_code, 8'h33);
    cur = 8'hD0;
    for (int s = 1; s < 5; s++) begin
      sel = 2'(s);
      nxt = 8'hD0 + {5'h00, sel, 1'b0};
      xfer(cur, 16'h0000, 1, {1'b0, sel, 13'h0000}, 1'b1, ok);
      repeat (10) @(posedge i_core_clk);
      chk(o_addr_select, sel);
      xfer(cur, 16'h0000, 0, 16'h0000, 1'b1, ok);
      chk(ok, 1'b0);
      xfer(nxt, 16'h0000, 0, 16'h0000, 1'b1, ok);
      chk(ok, 1'b1);
      cur = nxt;
    end
    xfer(8'hA0, 16'h0000, 0, 16'h0000, 1'b1, ok);
    chk(ok, 1'b0);
    i_core_power <= 1'b0;
    repeat (12) @(posedge i_core_clk);
    chk(o_suspend_32k, 1'b1);
    i_core_power <= 1'b1;
    repeat (12) @(posedge i_core_clk);
    chk(o_suspend_32k, 1'b0);
    i_vco_target <= 12'h005;
    repeat (4) @(posedge i_core_clk);
    chk(o_vco_setting < 12'h005, 1'b1);
    repeat (30) @(posedge i_core_clk);
    chk(o_vco_setting, 12'h005);
    i_vco_target <= 12'h003;
    repeat (30) @(posedge i_core_clk);
    chk(o_vco_setting, 12'h003);
    report_and_stop();
  end
endmodule : cgi_config_port_tb
bind cgi_config_port cgi_config_port_props #(.STEP_CYCLES(STEP_CYCLES))
  cgi_config_port_props_i (.*);
`default_nettype wire

// ---- verif/cgi_i2c_ctrl.sv ----
// Two-wire bus controller model driving the port's clock and data pins.
// Assumes a pull-up on data: o_sda high means released.
`default_nettype none
module cgi_i2c_ctrl #(
  parameter int Q = 10
) (
  input  wire logic i_core_clk,
  input  wire logic i_sda,
  output var  logic o_scl,
  output var  logic o_sda
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic step(input logic c, input logic d);
    repeat (Q) @(posedge i_core_clk);
    o_scl <= c;
    o_sda <= d;
  endtask : step
  task automatic bitx(input logic b, output logic r);
    step(1'b0, b);
    step(1'b1, b);
    repeat (Q) @(posedge i_core_clk);
    r = i_sda;
    step(1'b0, b);
  endtask : bitx
  // Works from idle and as a repeated start with the clock low.
  task automatic start();
    step(o_scl, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask : start
  task automatic stop();
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask : stop
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask : wbyte
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(last, r);
  endtask : rbyte
endmodule : cgi_i2c_ctrl
`default_nettype wire
